/* File: dpc_pkg.sv */
// package: constants and types for the ddr2 power and refresh command tracker
`default_nettype none
package dpc_pkg;
  // command codes as {ras_n, cas_n, we_n} with cs_n low
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ROW_W = 13; // 8192 rows
  localparam int APD_SLOW_BIT = 12; // mode bit selecting slow active exit
  // internal refresh timing
  localparam int RFC_NS = 105;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RFC_CYC = (RFC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SELF_REF_US = 7;
  localparam int SELF_REF_CYC = SELF_REF_US * 1000000 / CLK_PERIOD_PS; // longest, round down
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [ROW_W-1:0] ROW_RESET = 13'h0000;
  localparam logic [NUM_BANKS-1:0] BANKS_IDLE = 4'h0;
  typedef enum logic [2:0] {
    DPC_IDLE, DPC_ACTIVE, DPC_REFRESH, DPC_SELF_REF, DPC_PDN_PRE, DPC_PDN_ACT
  } dpc_state_e;
endpackage : dpc_pkg
`default_nettype wire

/* File: dpc_row_counter.sv */
// module: internal refresh row address counter
`timescale 1ns/1ps
`default_nettype none
module dpc_row_counter (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic step_i,
  output logic [dpc_pkg::ROW_W-1:0] row_o
);
  logic [dpc_pkg::ROW_W-1:0] row_q;
  logic [dpc_pkg::ROW_W-1:0] row_d;

  // wraps through every row; next refresh takes the next row
  always_comb begin
    row_d = row_q;
    if (step_i) begin
      row_d = row_q + 13'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      row_q <= dpc_pkg::ROW_RESET;
    end else begin
      row_q <= row_d;
    end
  end

  assign row_o = row_q;
endmodule : dpc_row_counter
`default_nettype wire

/* File: dpc_core.sv */
// module: ddr2 command decoder for refresh, self-refresh and power-down
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE_01: after auto-precharge, commands to other banks are accepted.
// RULE_02: controller spaces commands after auto-precharge per timing table.
// RULE_03: controller refreshes every row within any 64 ms window.
// RULE_04: controller averages one refresh per 7.8 us for 8192 rows.
// RULE_05: cs, ras, cas low, we high, cke high is auto-refresh; internal row.
// RULE_06: controller refreshes only after all banks precharged for precharge time.
// RULE_07: refresh leaves banks idle; controller waits refresh cycle time.
// RULE_08: controller postpones at most eight refreshes, gap under nine intervals.
// RULE_09: refresh command with cke falling enters self-refresh; banks idle.
// RULE_10: controller turns termination off before self-refresh and after exit delay.
// RULE_11: self-refresh ignores all but cke and refreshes from internal timer.
// RULE_12: controller may stop clock after entry, restarts before exit.
// RULE_13: controller holds cke high with nop during exit delay.
// RULE_14: controller waits read-exit delay for reads, non-read delay otherwise.
// RULE_15: cke registered low with nop or deselect enters power-down.
// RULE_16: cke may fall during activation, precharge, mode command or refresh.
// RULE_17: idle banks give precharge power-down, else active; bit 12 picks exit.
// RULE_18: power-down gates buffers; dll off except fast-exit active power-down.
// RULE_19: controller leaves power-down within nine refresh intervals.
// RULE_20: cke registered high with nop or deselect exits power-down.
// RULE_21: controller waits read latency plus half burst before active power-down.
// RULE_22: controller delays power-down after writes by the write recovery sums.
// RULE_23: power-down allowed after precharge, refresh or mode command.
// RULE_24: nop and deselect do nothing and end no running operation.
// RULE_25: controller keeps a postponed-refresh counter to force refreshes.
module dpc_core (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [dpc_pkg::BANK_W-1:0] bank_i,
  input wire logic ap_i,
  input wire logic mode_bit_i,
  output logic [dpc_pkg::NUM_BANKS-1:0] bank_open_o,
  output logic refresh_busy_o,
  output logic self_refresh_o,
  output logic power_down_o,
  output logic buffers_on_o,
  output logic dll_on_o,
  output logic refresh_strobe_o,
  output logic [dpc_pkg::ROW_W-1:0] refresh_row_o
);
  // pin synchronisers: two stages before decode
  logic [7:0] pin_s1_q;
  logic [7:0] pin_s2_q;
  logic [7:0] pin_raw;
  logic cke_prev_q;
  logic [dpc_pkg::BANK_W-1:0] bank_s1_q;
  logic [dpc_pkg::BANK_W-1:0] bank_s2_q;

  assign pin_raw = {mode_bit_i, ap_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, 1'b0};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      // nop with cke low, the pins' power-up level, so no false cke edge follows reset
      pin_s1_q <= 8'h0e;
      pin_s2_q <= 8'h0e;
      bank_s1_q <= 2'h0;
      bank_s2_q <= 2'h0;
      cke_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      bank_s1_q <= bank_i;
      bank_s2_q <= bank_s1_q;
      cke_prev_q <= pin_s2_q[5];
    end
  end

  logic cke;
  logic cs_n;
  logic [2:0] cmd;
  logic sel;
  logic apd_slow_q;
  logic apd_slow_d;
  assign cke = pin_s2_q[5];
  assign cs_n = pin_s2_q[4];
  assign cmd = pin_s2_q[3:1];
  // nop or deselect both count as no command
  assign sel = !cs_n && (cmd != dpc_pkg::CMD_NOP); // [RULE_24]

  dpc_pkg::dpc_state_e state_q;
  dpc_pkg::dpc_state_e state_d;
  logic [dpc_pkg::NUM_BANKS-1:0] open_q;
  logic [dpc_pkg::NUM_BANKS-1:0] open_d;
  logic [dpc_pkg::CNT_W-1:0] rfc_q;
  logic [dpc_pkg::CNT_W-1:0] rfc_d;
  logic [dpc_pkg::CNT_W-1:0] sr_q;
  logic [dpc_pkg::CNT_W-1:0] sr_d;
  logic step;

  // next-state decode; gating on cke_prev models the previous-cycle column
  always_comb begin
    state_d = state_q;
    open_d = open_q;
    rfc_d = (rfc_q != dpc_pkg::CNT_ZERO) ? rfc_q - 16'h0001 : rfc_q;
    sr_d = sr_q;
    apd_slow_d = apd_slow_q;
    step = 1'b0;
    unique case (state_q)
      dpc_pkg::DPC_IDLE, dpc_pkg::DPC_ACTIVE, dpc_pkg::DPC_REFRESH: begin
        if (cke_prev_q && sel && cmd == dpc_pkg::CMD_REF && cke) begin
          state_d = dpc_pkg::DPC_REFRESH; // [RULE_05]
          rfc_d = 16'(dpc_pkg::RFC_CYC);
          step = 1'b1;
        end else if (cke_prev_q && sel && cmd == dpc_pkg::CMD_REF && !cke) begin
          state_d = dpc_pkg::DPC_SELF_REF; // [RULE_09]
          sr_d = 16'(dpc_pkg::SELF_REF_CYC);
          step = 1'b1;
        end else if (cke_prev_q && !cke && !sel) begin
          // entry allowed even mid-refresh or mid-precharge
          state_d = (open_q == dpc_pkg::BANKS_IDLE) ? dpc_pkg::DPC_PDN_PRE
                                                    : dpc_pkg::DPC_PDN_ACT; // [RULE_15] [RULE_16] [RULE_17] [RULE_23]
        end else if (cke_prev_q && cke && sel) begin
          // other-bank commands pass untouched during auto-precharge
          if (cmd == dpc_pkg::CMD_ACT) begin
            open_d[bank_s2_q] = 1'b1; // [RULE_01]
          end else if (cmd == dpc_pkg::CMD_PRE) begin
            if (pin_s2_q[6]) begin
              open_d = dpc_pkg::BANKS_IDLE;
            end else begin
              open_d[bank_s2_q] = 1'b0;
            end
          end else if ((cmd == dpc_pkg::CMD_RD || cmd == dpc_pkg::CMD_WR) && pin_s2_q[6]) begin
            open_d[bank_s2_q] = 1'b0; // [RULE_01]
          end else if (cmd == dpc_pkg::CMD_MRS && bank_s2_q == 2'h0) begin
            apd_slow_d = pin_s2_q[7];
          end
          if (state_d != dpc_pkg::DPC_REFRESH) begin
            state_d = (open_d == dpc_pkg::BANKS_IDLE) ? dpc_pkg::DPC_IDLE
                                                      : dpc_pkg::DPC_ACTIVE;
          end
        end
        if (state_q == dpc_pkg::DPC_REFRESH && rfc_q == 16'h0001) begin
          state_d = dpc_pkg::DPC_IDLE; // [RULE_07]
          open_d = dpc_pkg::BANKS_IDLE;
        end
      end
      dpc_pkg::DPC_SELF_REF: begin
        // only cke is heard; internal timer keeps rows alive
        sr_d = sr_q - 16'h0001; // [RULE_11]
        if (sr_q == 16'h0001) begin
          sr_d = 16'(dpc_pkg::SELF_REF_CYC);
          step = 1'b1;
        end
        if (cke) begin
          state_d = dpc_pkg::DPC_IDLE;
          open_d = dpc_pkg::BANKS_IDLE;
        end
      end
      dpc_pkg::DPC_PDN_PRE, dpc_pkg::DPC_PDN_ACT: begin
        if (cke && !sel) begin
          state_d = (open_q == dpc_pkg::BANKS_IDLE) ? dpc_pkg::DPC_IDLE
                                                    : dpc_pkg::DPC_ACTIVE; // [RULE_20]
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= dpc_pkg::DPC_IDLE;
      open_q <= dpc_pkg::BANKS_IDLE;
      rfc_q <= dpc_pkg::CNT_ZERO;
      sr_q <= dpc_pkg::CNT_ZERO;
      apd_slow_q <= 1'b0;
    end else begin
      state_q <= state_d;
      open_q <= open_d;
      rfc_q <= rfc_d;
      sr_q <= sr_d;
      apd_slow_q <= apd_slow_d;
    end
  end

  // registered status outputs
  logic busy_q;
  logic self_q;
  logic pdn_q;
  logic buf_q;
  logic dll_q;
  logic strobe_q;
  logic busy_d;
  logic self_d;
  logic pdn_d;
  logic buf_d;
  logic dll_d;

  always_comb begin
    // a refresh keeps running after cke falls, so busy follows the cycle counter
    busy_d = (rfc_d != dpc_pkg::CNT_ZERO); // [RULE_16]
    self_d = (state_d == dpc_pkg::DPC_SELF_REF);
    pdn_d = (state_d == dpc_pkg::DPC_PDN_PRE) || (state_d == dpc_pkg::DPC_PDN_ACT);
    // buffers off in any low-power state to save power
    buf_d = !(pdn_d || self_d); // [RULE_18]
    dll_d = !(self_d || state_d == dpc_pkg::DPC_PDN_PRE
              || (state_d == dpc_pkg::DPC_PDN_ACT && apd_slow_q)); // [RULE_18] [RULE_17]
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      busy_q <= 1'b0;
      self_q <= 1'b0;
      pdn_q <= 1'b0;
      buf_q <= 1'b1;
      dll_q <= 1'b1;
      strobe_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      self_q <= self_d;
      pdn_q <= pdn_d;
      buf_q <= buf_d;
      dll_q <= dll_d;
      strobe_q <= step;
    end
  end

  logic [dpc_pkg::ROW_W-1:0] row_w;
  // row address never taken from pins
  dpc_row_counter u_rows (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .step_i(step),
    .row_o(row_w)
  ); // [RULE_05]

  assign bank_open_o = open_q;
  assign refresh_busy_o = busy_q;
  assign self_refresh_o = self_q;
  assign power_down_o = pdn_q;
  assign buffers_on_o = buf_q;
  assign dll_on_o = dll_q;
  assign refresh_strobe_o = strobe_q;
  assign refresh_row_o = row_w;

  chk_ref_idle: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_07]
    state_q == dpc_pkg::DPC_REFRESH && rfc_q == 16'h0001 |=> open_q == 4'h0)
    else $error("banks not idle after refresh");
  chk_self_entry: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_09]
    state_q == dpc_pkg::DPC_IDLE && cke_prev_q && !cke && sel && cmd == dpc_pkg::CMD_REF
    |=> self_refresh_o && !buffers_on_o)
    else $error("self refresh not entered");
  chk_self_hold: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_11]
    state_q == dpc_pkg::DPC_SELF_REF && !cke |=> state_q == dpc_pkg::DPC_SELF_REF)
    else $error("self refresh left while cke low");
  chk_pdn_entry: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_15]
    (state_q == dpc_pkg::DPC_IDLE || state_q == dpc_pkg::DPC_ACTIVE) && cke_prev_q && !cke && !sel
    |=> power_down_o)
    else $error("power down not entered");
  chk_busy_pdn: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_16]
    state_q == dpc_pkg::DPC_REFRESH && cke_prev_q && !cke && !sel && rfc_q > 16'h0001
    |=> power_down_o && refresh_busy_o)
    else $error("refresh cut by power down");
  chk_pdn_exit: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_20]
    power_down_o && $rose(cke) && !sel |=> !power_down_o)
    else $error("power down not exited");
  chk_dll_mode: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_18]
    state_q == dpc_pkg::DPC_PDN_ACT && !apd_slow_q |=> ##[0:1] dll_on_o || !power_down_o)
    else $error("dll off in fast exit");
  chk_ref_strobe: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_05]
    $rose(refresh_busy_o) |-> strobe_q && refresh_row_o == $past(refresh_row_o) + 13'h0001)
    else $error("refresh row not advanced");
  chk_nop_hold: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_24]
    state_q == dpc_pkg::DPC_REFRESH && !sel && cke && rfc_q > 16'h0001
    |=> state_q == dpc_pkg::DPC_REFRESH)
    else $error("nop ended refresh");
endmodule : dpc_core
`default_nettype wire

/* File: dpc_ctrl_model.sv */
// controller-side partner: drives the ddr2 command pins one cycle at a time
`timescale 1ns/1ps
`default_nettype none
module dpc_ctrl_model (
  input wire logic clk_i,
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [dpc_pkg::BANK_W-1:0] bank_o,
  output logic ap_o,
  output logic mode_bit_o
);
  integer seed = 32'hdb7a;
  localparam int REFI_CYC = 1560; // average refresh interval, 7.8 us at 5 ns
  logic nxt_cke = 1'b0; // cke low as after power-up
  logic [3:0] nxt_cmd = 4'hf; // {cs_n, ras_n, cas_n, we_n}, deselect
  logic [1:0] nxt_bank = 2'h0;
  logic nxt_ap = 1'b0;
  logic nxt_mode = 1'b0;
  logic rand_on = 1'b0;
  logic junk_on = 1'b0;
  logic use_rnd;
  logic [7:0] rnd;
  logic cke_last = 1'b0;
  int tick = 0;
  int owed = 0;

  // pins launched 1 ns after each rising edge; requests are written on the edge itself
  always @(posedge clk_i) begin
    #1;
    rnd = 8'($random(seed));
    // junk gives random commands, only legal with cke held low
    use_rnd = rand_on && (rnd[0] || junk_on);
    cke_o = nxt_cke;
    cs_n_o = rand_on ? rnd[0] : nxt_cmd[3];
    {ras_n_o, cas_n_o, we_n_o} = use_rnd ? rnd[3:1] : nxt_cmd[2:0];
    bank_o = rand_on ? rnd[5:4] : nxt_bank;
    ap_o = rand_on ? rnd[6] : nxt_ap;
    mode_bit_o = rand_on ? rnd[7] : nxt_mode;
  end

  // postponed-refresh ledger: one owed per average interval, one paid per refresh registered
  always @(posedge clk_i) begin
    cke_last <= cke_o;
    tick <= (tick == REFI_CYC - 1) ? 0 : tick + 1;
    owed <= owed + int'(tick == REFI_CYC - 1)
            - int'(cke_last && {cs_n_o, ras_n_o, cas_n_o, we_n_o} == 4'h1);
  end

  // one command on the next edge; pins follow 1 ns later
  task automatic send(input logic [2:0] c, input logic k, input logic [1:0] b,
                      input logic a, input logic m);
    @(posedge clk_i);
    rand_on = 1'b0;
    nxt_cke = k;
    nxt_cmd = {1'b0, c};
    nxt_bank = b;
    nxt_ap = a;
    nxt_mode = m;
    #1;
  endtask : send

  // n cycles of nop or deselect, or random commands when junk is set, with random address pins
  task automatic idle(input int n, input logic k, input logic junk);
    repeat (n) begin
      @(posedge clk_i);
      rand_on = 1'b1;
      junk_on = junk;
      nxt_cke = k;
      nxt_cmd = 4'hf;
      #1;
    end
  endtask : idle
endmodule : dpc_ctrl_model
`default_nettype wire

/* File: ddr2_refresh_powerdown_timing_bench.sv */
// self-checking bench for the ddr2 refresh and power-down tracker
`timescale 1ns/1ps
`default_nettype none
module ddr2_refresh_powerdown_timing_bench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, ap, mb;
  logic [dpc_pkg::BANK_W-1:0] bank;
  logic [dpc_pkg::NUM_BANKS-1:0] bank_open;
  logic busy, sr, pd, buf_on, dll_on, strobe;
  logic [dpc_pkg::ROW_W-1:0] row;
  logic [dpc_pkg::ROW_W-1:0] exp_row = 13'h0000;
  logic [dpc_pkg::ROW_W-1:0] r0;
  logic [2:0] seen_q = 3'h0;
  logic [2:0] notes[$];
  int num_errors = 0;
  int check_count = 0;

  initial forever #2.5 clk_i = ~clk_i;

  dpc_ctrl_model u_ctl (.clk_i(clk_i), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
    .cas_n_o(cas_n), .we_n_o(we_n), .bank_o(bank), .ap_o(ap), .mode_bit_o(mb));

  dpc_core u_dut (.clk_i(clk_i), .reset_i(reset_i), .cke_i(cke), .cs_n_i(cs_n),
    .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .bank_i(bank), .ap_i(ap),
    .mode_bit_i(mb), .bank_open_o(bank_open), .refresh_busy_o(busy),
    .self_refresh_o(sr), .power_down_o(pd), .buffers_on_o(buf_on), .dll_on_o(dll_on),
    .refresh_strobe_o(strobe), .refresh_row_o(row));

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      num_errors++;
      $display("mismatch at %0t: seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // watcher: each change of busy/self-refresh/power-down takes the oldest note
  always @(posedge clk_i) begin
    #2;
    if (!reset_i && strobe === 1'b1) begin
      // the row register has already advanced when the strobe shows
      exp_row++;
      check(row, exp_row);
    end
    if (!reset_i && {busy, sr, pd} !== seen_q) begin
      seen_q = {busy, sr, pd};
      check(seen_q, notes.size() > 0 ? notes.pop_front() : ~seen_q);
    end
  end

  // watchdog sized well past the ~3100-cycle sequence
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    u_ctl.idle(4, 1'b1, 1'b0);
    check({buf_on, dll_on, bank_open, busy, sr, pd, strobe}, 10'h300);
    // auto-refresh with junk on the address pins; nops must not cut it short
    notes.push_back(3'h4);
    notes.push_back(3'h0);
    u_ctl.send(dpc_pkg::CMD_REF, 1'b1, 2'h3, 1'b1, 1'b1);
    u_ctl.idle(3, 1'b1, 1'b0);
    check({busy, strobe}, 2'h3);
    u_ctl.idle(dpc_pkg::RFC_CYC - 1, 1'b1, 1'b0);
    check(busy, 1'b1);
    u_ctl.idle(1, 1'b1, 1'b0);
    check({busy, bank_open}, 5'h00);
    // read with auto-precharge, other bank activated one cycle later
    u_ctl.send(dpc_pkg::CMD_ACT, 1'b1, 2'h0, 1'b0, 1'b0);
    u_ctl.send(dpc_pkg::CMD_ACT, 1'b1, 2'h2, 1'b0, 1'b0);
    u_ctl.idle(2, 1'b1, 1'b0);
    u_ctl.send(dpc_pkg::CMD_RD, 1'b1, 2'h0, 1'b1, 1'b0);
    u_ctl.send(dpc_pkg::CMD_ACT, 1'b1, 2'h1, 1'b0, 1'b0);
    u_ctl.idle(4, 1'b1, 1'b0);
    check(bank_open, 4'h6);
    // write with auto-precharge to bank 2, spaced past the read burst
    u_ctl.send(dpc_pkg::CMD_WR, 1'b1, 2'h2, 1'b1, 1'b0);
    u_ctl.idle(30, 1'b1, 1'b0); // bursts and recovery over before power-down
    check(bank_open, 4'h2);
    // active power-down, slow exit then fast exit; commands inside are ignored
    for (int m = 1; m >= 0; m--) begin
      u_ctl.send(dpc_pkg::CMD_PRE, 1'b1, 2'h0, 1'b1, 1'b0);
      u_ctl.idle(3, 1'b1, 1'b0);
      u_ctl.send(dpc_pkg::CMD_MRS, 1'b1, 2'h0, 1'b0, m[0]);
      u_ctl.idle(3, 1'b1, 1'b0);
      u_ctl.send(dpc_pkg::CMD_ACT, 1'b1, 2'h3, 1'b0, 1'b0);
      u_ctl.idle(3, 1'b1, 1'b0);
      notes.push_back(3'h1);
      notes.push_back(3'h0);
      u_ctl.idle(4, 1'b0, 1'b0);
      u_ctl.idle(6, 1'b0, 1'b1);
      check({buf_on, dll_on, bank_open}, {1'b0, ~m[0], 4'h8});
      u_ctl.idle(6, 1'b1, 1'b0);
      check({buf_on, dll_on, bank_open}, 6'h38);
    end
    // precharge power-down right after a precharge-all
    u_ctl.send(dpc_pkg::CMD_PRE, 1'b1, 2'h2, 1'b1, 1'b0);
    u_ctl.idle(1, 1'b1, 1'b0);
    notes.push_back(3'h1);
    notes.push_back(3'h0);
    u_ctl.idle(6, 1'b0, 1'b0);
    check({buf_on, dll_on, bank_open}, 6'h00);
    u_ctl.idle(6, 1'b1, 1'b0);
    // power-down entered while an auto-refresh is still running
    notes.push_back(3'h4);
    notes.push_back(3'h5);
    notes.push_back(3'h1);
    notes.push_back(3'h0);
    u_ctl.send(dpc_pkg::CMD_REF, 1'b1, 2'h1, 1'b0, 1'b1);
    u_ctl.idle(4, 1'b1, 1'b0);
    u_ctl.idle(dpc_pkg::RFC_CYC + 5, 1'b0, 1'b0);
    check({buf_on, dll_on}, 2'h0);
    u_ctl.idle(6, 1'b1, 1'b0);
    // self-refresh: random commands ignored, internal timer keeps refreshing
    r0 = exp_row;
    notes.push_back(3'h2);
    notes.push_back(3'h0);
    u_ctl.idle(3, 1'b1, 1'b0);
    u_ctl.send(dpc_pkg::CMD_REF, 1'b0, 2'h2, 1'b1, 1'b0); // termination never on
    u_ctl.idle(2 * dpc_pkg::SELF_REF_CYC + 100, 1'b0, 1'b1); // clock left running
    check(exp_row - r0, 13'h0003); // one row at entry, two from the timer
    u_ctl.idle(8, 1'b1, 1'b0);
    check({bank_open, notes.size() == 0}, 5'h01);
    check(u_ctl.owed <= 8, 1'b1);
    report_and_stop();
  end
endmodule : ddr2_refresh_powerdown_timing_bench
`default_nettype wire
